// ==== include/output_compare_map.vh ====
`ifndef OUTPUT_COMPARE_MAP_VH
`define OUTPUT_COMPARE_MAP_VH

// ----------------------------------------
// register offsets (word index)
// ----------------------------------------
`define OC_ADDR_CONTROL_ONE   4'h0
`define OC_ADDR_CONTROL_TWO   4'h1
`define OC_ADDR_PRIMARY       4'h2
`define OC_ADDR_SECONDARY     4'h3
`define OC_ADDR_PERIOD        4'h4
`define OC_ADDR_COUNTER       4'h5
`define OC_ADDR_STATUS        4'h6

// ----------------------------------------
// control one fields
// ----------------------------------------
`define OC_C1_MODE_LSB        0
`define OC_C1_REARM_BIT       3
`define OC_C1_TBSEL_LSB       10
`define OC_C1_RESET           16'h0000
`define OC_C1_MASK            16'h1c0f

// ----------------------------------------
// control two fields
// ----------------------------------------
`define OC_C2_SYNC_LSB        0
`define OC_C2_TRIGGER_STATUS_BIT    6
`define OC_C2_TRIGSEL_BIT     7
`define OC_C2_CASCADE_BIT     8
`define OC_C2_RESET           16'h0000
`define OC_C2_MASK            16'h01df

// ----------------------------------------
// compare modes
// ----------------------------------------
`define OC_MODE_OFF           3'h0
`define OC_MODE_SINGLE_HIGH   3'h1
`define OC_MODE_SINGLE_LOW    3'h2
`define OC_MODE_TOGGLE        3'h3
`define OC_MODE_DUAL_SINGLE   3'h4
`define OC_MODE_DUAL_CONT     3'h5

`define OC_SYNC_NONE          5'h00
`define OC_PERIOD_RESET       16'hffff

`endif

// ==== hdl/compare_event_sync.v ====
`timescale 1ns/1ps

// ----------------------------------------
// one-of-n source selector with edge pulse
// ----------------------------------------
module compare_event_sync
#(
  parameter SOURCES = 32
)
(
  // clock and reset
  input  wire               clock,
  input  wire               reset,
  // selection
  input  wire [SOURCES-1:0] sources,
  input  wire [4:0]         select,
  // result
  output wire               event_pulse
);

  reg  previous;
  wire level;

  // index 0 means no source; it never fires
  assign level       = (select != 5'h00) ? sources[select] : 1'b0;
  assign event_pulse = level & ~previous;

  always @(posedge clock or posedge reset)
  begin
    if (reset)
      previous <= 1'b0;
    else
      previous <= level;
  end

endmodule

// ==== hdl/output_compare_timer.v ====
`timescale 1ns/1ps
`include "output_compare_map.vh"

// Behaviour
// - own 16-bit counter, one of six time base ticks selects counting
// - free-running counter counts up and wraps from the period value to 0x0000
// - compare event when counter equals primary or secondary value
// - synchronous mode runs at once; sync event clears counter
// - trigger mode holds counter until selected source event
// - sync select zero means free-running; nonzero means sync or trigger
// - control two bit 7 set means trigger, clear means synchronous
// - five-bit sync select gives 31 sources plus no-source code
// - cascaded: odd is low half, its wrap increments even half
// - cascade active only when both modules set control two bit 8
// - mode field values 1 to 5 select compare operation; 0, 6 and 7 leave it off
// - pin rests at default, goes opposite on primary match
// - double compare modes return pin to default on secondary match
// - flag on primary match single modes, secondary match double modes
// - single-shot once until control one rewritten; continuous repeats
// - toggle mode flips pin on every primary match
// - rearm bit and trigger status choose trigger behaviour
module output_compare_timer
#(
  parameter WIDTH   = 16,
  parameter SOURCES = 32
)
(
  // clock and reset
  input  wire               clock,
  input  wire               reset,
  // register port
  input  wire [3:0]         address,
  input  wire [15:0]        write_data,
  input  wire               write_strobe,
  input  wire               read_strobe,
  output reg  [15:0]        read_data,
  // time base ticks, one per selectable source
  input  wire [5:0]         time_base_ticks,
  // sync and trigger sources, index 0 unused
  input  wire [SOURCES-1:0] sync_sources,
  // cascade partner
  input  wire               partner_cascade_enable,
  input  wire               carry_in,
  output wire               carry_out,
  output wire               cascade_active,
  // compare output pin
  output reg                compare_output,
  output wire               output_pin_direction,
  // events
  output reg                compare_interrupt_flag,
  output wire               sync_event_out
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg  [15:0]      compare_control_one;
  reg  [15:0]      compare_control_two;
  reg  [WIDTH-1:0] primary_compare_value;
  reg  [WIDTH-1:0] secondary_compare_value;
  reg  [WIDTH-1:0] timer_period;
  reg  [WIDTH-1:0] module_counter;
  reg              shot_done;
  reg              next_output;
  reg              next_flag;
  reg              next_done;

  wire [2:0] compare_mode_field;
  wire [2:0] time_base_select;
  wire [4:0] sync_source_select;
  wire       trigger_or_sync_select;
  wire       trigger_status;
  wire       trigger_rearm_mode;
  wire       cascade_enable;
  wire       tick;
  wire       source_event;
  wire       free_running;
  wire       trigger_mode;
  wire       running;
  wire       count_step;
  wire       at_period;
  wire       primary_match;
  wire       secondary_match;
  wire       compare_on;
  wire       double_mode;
  wire       continuous;
  wire       ctl1_write;

  assign compare_mode_field     = compare_control_one[`OC_C1_MODE_LSB +: 3];
  assign time_base_select       = compare_control_one[`OC_C1_TBSEL_LSB +: 3];
  assign trigger_rearm_mode     = compare_control_one[`OC_C1_REARM_BIT];
  assign sync_source_select     = compare_control_two[`OC_C2_SYNC_LSB +: 5];
  assign trigger_status         = compare_control_two[`OC_C2_TRIGGER_STATUS_BIT];
  assign trigger_or_sync_select = compare_control_two[`OC_C2_TRIGSEL_BIT];
  assign cascade_enable         = compare_control_two[`OC_C2_CASCADE_BIT];
  assign ctl1_write = write_strobe && (address == `OC_ADDR_CONTROL_ONE);

  // ----------------------------------------
  // time base and source selection
  // ----------------------------------------
  // codes 5 and 6 are reserved and never tick
  assign tick = (time_base_select == 3'h7) ? time_base_ticks[5] :
                (time_base_select <  3'h5) ? time_base_ticks[time_base_select] : 1'b0;

  compare_event_sync
  #(
    .SOURCES (SOURCES)
  )
  source_select
  (
    .clock       (clock),
    .reset       (reset),
    .sources     (sync_sources),
    .select      (sync_source_select),
    .event_pulse (source_event)
  );

  assign free_running   = (sync_source_select == `OC_SYNC_NONE);
  assign trigger_mode   = !free_running && trigger_or_sync_select;
  assign cascade_active = cascade_enable && partner_cascade_enable;
  assign running        = !trigger_mode || trigger_status;

  // even half of a pair counts on the odd half's wrap, not on the tick
  assign count_step = cascade_active ? carry_in : tick;
  assign at_period  = (module_counter == timer_period);
  assign carry_out  = tick && running && at_period;
  assign sync_event_out = carry_out;

  // ----------------------------------------
  // counter
  // ----------------------------------------
  always @(posedge clock or posedge reset)
  begin
    if (reset)
      module_counter <= {WIDTH{1'b0}};
    else if (trigger_mode && !trigger_status)
      module_counter <= {WIDTH{1'b0}};
    else if (!trigger_mode && !free_running && source_event)
      module_counter <= {WIDTH{1'b0}};
    else if (count_step && running)
    begin
      // period left at all ones gives a plain 0xffff to 0x0000 wrap
      if (at_period)
        module_counter <= {WIDTH{1'b0}};
      else
        module_counter <= module_counter + 1'b1;
    end
  end

  // ----------------------------------------
  // compare logic
  // ----------------------------------------
  // matches count only on a counting step, so a held counter cannot retrigger
  assign primary_match   = running && count_step &&
                           (module_counter == primary_compare_value);
  assign secondary_match = running && count_step &&
                           (module_counter == secondary_compare_value);
  assign compare_on  = !compare_mode_field[2] && (compare_mode_field != `OC_MODE_OFF) ||
                       (compare_mode_field == `OC_MODE_DUAL_SINGLE) ||
                       (compare_mode_field == `OC_MODE_DUAL_CONT);
  assign double_mode = (compare_mode_field == `OC_MODE_DUAL_SINGLE) ||
                       (compare_mode_field == `OC_MODE_DUAL_CONT);
  assign continuous  = (compare_mode_field == `OC_MODE_DUAL_CONT) ||
                       (compare_mode_field == `OC_MODE_TOGGLE);
  assign output_pin_direction = compare_on;

  always @*
  begin
    next_output = compare_output;
    next_flag   = 1'b0;
    next_done   = shot_done;
    case (compare_mode_field)
      `OC_MODE_OFF:
        next_output = 1'b0;
      `OC_MODE_SINGLE_HIGH:
        if (primary_match && !shot_done)
        begin
          next_output = 1'b1;
          next_flag   = 1'b1;
          next_done   = 1'b1;
        end
      `OC_MODE_SINGLE_LOW:
        if (primary_match && !shot_done)
        begin
          next_output = 1'b0;
          next_flag   = 1'b1;
          next_done   = 1'b1;
        end
      `OC_MODE_TOGGLE:
        if (primary_match && count_step)
        begin
          next_output = !compare_output;
          next_flag   = 1'b1;
        end
      `OC_MODE_DUAL_SINGLE, `OC_MODE_DUAL_CONT:
        if (!shot_done || continuous)
        begin
          if (secondary_match && compare_output && count_step)
          begin
            next_output = 1'b0;
            next_flag   = 1'b1;
            next_done   = !continuous;
          end
          else if (primary_match && count_step)
            next_output = 1'b1;
        end
      default:
        next_output = 1'b0;
    endcase
  end

  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      compare_output         <= 1'b0;
      compare_interrupt_flag <= 1'b0;
      shot_done              <= 1'b0;
    end
    else
    begin
      compare_output         <= next_output;
      compare_interrupt_flag <= next_flag;
      // rewriting control one re-arms a single shot
      shot_done              <= ctl1_write ? 1'b0 : next_done;
    end
  end

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      compare_control_one     <= `OC_C1_RESET;
      compare_control_two     <= `OC_C2_RESET;
      primary_compare_value   <= {WIDTH{1'b0}};
      secondary_compare_value <= {WIDTH{1'b0}};
      timer_period            <= `OC_PERIOD_RESET;
    end
    else
    begin
      if (ctl1_write)
        compare_control_one <= write_data & `OC_C1_MASK;
      if (write_strobe && (address == `OC_ADDR_CONTROL_TWO))
        compare_control_two <= write_data & `OC_C2_MASK;
      else if (trigger_mode && source_event)
        compare_control_two[`OC_C2_TRIGGER_STATUS_BIT] <= 1'b1;
      else if (trigger_mode && trigger_rearm_mode && carry_out)
        // rearm: a completed period drops the status to await a new trigger
        compare_control_two[`OC_C2_TRIGGER_STATUS_BIT] <= 1'b0;
      if (write_strobe && (address == `OC_ADDR_PRIMARY))
        primary_compare_value <= write_data[WIDTH-1:0];
      if (write_strobe && (address == `OC_ADDR_SECONDARY))
        secondary_compare_value <= write_data[WIDTH-1:0];
      if (write_strobe && (address == `OC_ADDR_PERIOD))
        timer_period <= write_data[WIDTH-1:0];
    end
  end

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  always @(posedge clock or posedge reset)
  begin
    if (reset)
      read_data <= 16'h0000;
    else if (read_strobe)
    begin
      case (address)
        `OC_ADDR_CONTROL_ONE: read_data <= compare_control_one;
        `OC_ADDR_CONTROL_TWO: read_data <= compare_control_two;
        `OC_ADDR_PRIMARY:     read_data <= primary_compare_value;
        `OC_ADDR_SECONDARY:   read_data <= secondary_compare_value;
        `OC_ADDR_PERIOD:      read_data <= timer_period;
        `OC_ADDR_COUNTER:     read_data <= module_counter;
        `OC_ADDR_STATUS:      read_data <= {13'h0000, cascade_active, shot_done,
                                            compare_output};
        default:              read_data <= 16'h0000;
      endcase
    end
    else
      read_data <= 16'h0000;
  end

endmodule

// ==== dv/oc_timer_chk.sv ====
`timescale 1ns/1ps

// ----------------------------------------
// port checker for the compare timer
// ----------------------------------------
module oc_timer_chk
(
  // clock and reset
  input wire        clock,
  input wire        reset,
  // register port
  input wire        write_strobe,
  input wire        read_strobe,
  input wire [15:0] read_data,
  // time base and cascade
  input wire [5:0]  time_base_ticks,
  input wire        partner_cascade_enable,
  input wire        carry_in,
  input wire        carry_out,
  input wire        cascade_active,
  // pin and events
  input wire        compare_output,
  input wire        compare_interrupt_flag,
  input wire        sync_event_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  // ----------------------------------------
  // sequences and properties
  // ----------------------------------------
  sequence s_read_done;
    read_strobe ##1 !read_strobe;
  endsequence
  sequence s_tick_recent;
    $past(|time_base_ticks || carry_in) || $past(|time_base_ticks || carry_in, 2);
  endsequence

  // read data must not linger past its one cycle
  property p_rd_window;
    s_read_done |=> read_data == 16'h0;
  endproperty
  property p_rd_quiet;
    !$past(read_strobe) |-> read_data == 16'h0;
  endproperty
  property p_carry_tick;
    carry_out |-> |time_base_ticks;
  endproperty
  property p_sync_carry;
    sync_event_out == carry_out;
  endproperty
  property p_cascade;
    cascade_active |-> partner_cascade_enable;
  endproperty
  property p_flag_pulse;
    compare_interrupt_flag |=> !compare_interrupt_flag;
  endproperty
  property p_flag_cause;
    compare_interrupt_flag |-> s_tick_recent;
  endproperty
  // a software write may also move the pin, so it counts as a cause
  property p_pin_cause;
    $changed(compare_output) |-> s_tick_recent or $past(write_strobe) or $past(write_strobe, 2);
  endproperty

  a_rd_window:  assert property (p_rd_window)  else $error("read data lingered");
  a_rd_quiet:   assert property (p_rd_quiet)   else $error("read data without read");
  a_carry_tick: assert property (p_carry_tick) else $error("wrap without tick");
  a_sync_carry: assert property (p_sync_carry) else $error("sync event differs from carry");
  a_cascade:    assert property (p_cascade)    else $error("cascade without partner bit");
  a_flag_pulse: assert property (p_flag_pulse) else $error("flag longer than one cycle");
  a_flag_cause: assert property (p_flag_cause) else $error("flag without counting");
  a_pin_cause:  assert property (p_pin_cause)  else $error("pin moved without cause");
endmodule

bind output_compare_timer oc_timer_chk u_chk (
  .clock(clock), .reset(reset), .write_strobe(write_strobe), .read_strobe(read_strobe),
  .read_data(read_data), .time_base_ticks(time_base_ticks),
  .partner_cascade_enable(partner_cascade_enable), .carry_in(carry_in),
  .carry_out(carry_out),
  .cascade_active(cascade_active), .compare_output(compare_output),
  .compare_interrupt_flag(compare_interrupt_flag), .sync_event_out(sync_event_out));

// ==== dv/ext_load.sv ====
`timescale 1ns/1ps

// ----------------------------------------
// external circuit counting pin edges
// ----------------------------------------
module ext_load
(
  // clock and reset
  input wire clock,
  input wire reset,
  // pin
  input wire pin,
  input wire enable
);
  integer rises;
  integer falls;
  reg     last;
  // an undriven pin is not judged, so edges count only while enabled
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      rises <= 0;
      falls <= 0;
      last  <= 1'b0;
    end
    else if (enable)
    begin
      if (pin && !last) rises <= rises + 1;
      if (!pin && last) falls <= falls + 1;
      last <= pin;
    end
  end
endmodule

// ==== dv/tb_output_compare_timer.sv ====
`timescale 1ns/1ps

module tb_output_compare_timer;
  reg         clock = 1'b0;
  reg         reset = 1'b1;
  reg  [3:0]  address = 4'h0;
  reg  [15:0] write_data = 16'h0;
  reg         write_strobe = 1'b0;
  reg         read_strobe = 1'b0;
  reg  [5:0]  time_base_ticks = 6'h0;
  reg  [31:0] sync_sources = 32'h0;
  reg         partner_cascade_enable = 1'b0;
  reg         carry_in = 1'b0;
  wire [15:0] read_data;
  wire        carry_out, cascade_active, compare_output;
  wire        output_pin_direction, compare_interrupt_flag, sync_event_out;
  integer     mismatches = 0, cmp_count = 0, n_flag, n_carry, e0, e1;
  reg  [15:0] d, c0;

  always #5 clock = ~clock;

  output_compare_timer dut (
    .clock(clock), .reset(reset), .address(address), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
    .time_base_ticks(time_base_ticks), .sync_sources(sync_sources),
    .partner_cascade_enable(partner_cascade_enable), .carry_in(carry_in),
    .carry_out(carry_out), .cascade_active(cascade_active), .compare_output(compare_output),
    .output_pin_direction(output_pin_direction),
    .compare_interrupt_flag(compare_interrupt_flag), .sync_event_out(sync_event_out));

  ext_load u_load (.clock(clock), .reset(reset), .pin(compare_output),
    .enable(output_pin_direction));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task chk(input string name, input [15:0] exp, input [15:0] got);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp)
      begin
        mismatches = mismatches + 1;
        $display("[ERR] %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task wr(input [3:0] a, input [15:0] v);
    begin
      @(posedge clock);
      address <= a; write_data <= v; write_strobe <= 1'b1;
      @(posedge clock);
      write_strobe <= 1'b0;
    end
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input [3:0] a);
    begin
      @(posedge clock);
      address <= a; read_strobe <= 1'b1;
      @(posedge clock);
      read_strobe <= 1'b0;
      #1 d = read_data;
    end
  endtask
  task run(input integer n);
    begin
      n_flag = 0; n_carry = 0;
      repeat (n)
      begin
        @(posedge clock);
        #1 n_flag = n_flag + compare_interrupt_flag;
        n_carry = n_carry + carry_out;
      end
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // the counter is not writable, so a sync event is used here to bring it back to zero
  task clr_count;
    begin
      time_base_ticks <= 6'h00;
      sync_sources[1] <= 1'b1;
      wr(4'h1, 16'h0001);
      wr(4'h1, 16'h0000);
      sync_sources[1] <= 1'b0;
    end
  endtask
  task t_reset;
    begin
      rd(4'h1); chk("control_two", 16'h0000, d);
      rd(4'h4); chk("period", 16'hffff, d);
      rd(4'h7); chk("unmapped", 16'h0000, d);
      $display("test reset done");
    end
  endtask
  task t_wrap;
    begin
      wr(4'h0, 16'h1c00); time_base_ticks <= 6'h3f;
      run(65540); chk("wraps", 16'h1, n_carry[15:0]);
      chk("pin_dir_off", 16'h0, {15'h0, output_pin_direction});
      rd(4'h5); c0 = d;
      rd(4'h5); chk("count_step", c0 + 16'h2, d);
      $display("test wrap done");
    end
  endtask
  task t_single;
    begin
      clr_count;
      wr(4'h4, 16'h0009);
      wr(4'h2, 16'h0003);
      wr(4'h3, 16'h0006);
      time_base_ticks <= 6'h3f;
      wr(4'h0, 16'h1c01);
      run(60); chk("shot_flags", 16'h1, n_flag[15:0]);
      chk("shot_pin", 16'h1, {15'h0, compare_output});
      chk("pin_dir_on", 16'h1, {15'h0, output_pin_direction});
      wr(4'h0, 16'h1c01); run(60); chk("rearm_flags", 16'h1, n_flag[15:0]);
      wr(4'h0, 16'h1c02); run(30); chk("low_flags", 16'h1, n_flag[15:0]);
      chk("low_pin", 16'h0, {15'h0, compare_output});
      e0 = u_load.rises;
      wr(4'h0, 16'h1c04); run(30); chk("dual_flags", 16'h1, n_flag[15:0]);
      chk("dual_rises", 16'h1, u_load.rises - e0);
      chk("dual_pin", 16'h0, {15'h0, compare_output});
      $display("test single done");
    end
  endtask
  task t_cont;
    begin
      wr(4'h0, 16'h1c05); run(5);
      e0 = u_load.rises; e1 = u_load.falls;
      run(100); chk("cont_flags", 16'd10, n_flag[15:0]);
      chk("cont_rises", 16'd10, u_load.rises - e0);
      chk("cont_falls", 16'd10, u_load.falls - e1);
      wr(4'h0, 16'h1c03); run(5);
      e0 = u_load.rises + u_load.falls;
      run(100); chk("toggles", 16'd10, u_load.rises + u_load.falls - e0);
      $display("test continuous done");
    end
  endtask
  task t_sync_trig;
    begin
      wr(4'h1, 16'h0001); time_base_ticks <= 6'h0; sync_sources[1] <= 1'b1;
      run(4); rd(4'h5); chk("sync_clear", 16'h0, d);
      sync_sources[1] <= 1'b0; time_base_ticks <= 6'h3f;
      wr(4'h1, 16'h0082); run(10);
      rd(4'h5); chk("trig_hold", 16'h0, d);
      rd(4'h1); chk("trig_wait", 16'h0082, d);
      sync_sources[2] <= 1'b1; run(10);
      rd(4'h1); chk("trig_status", 16'h00c2, d);
      rd(4'h5); chk("trig_run", 16'h1, {15'h0, d !== 16'h0});
      wr(4'h0, 16'h1c0b); run(12);
      rd(4'h1); chk("rearm_status", 16'h0082, d);
      rd(4'h5); chk("rearm_hold", 16'h0, d);
      wr(4'h1, 16'h0000); sync_sources[2] <= 1'b0;
      $display("test sync and trigger done");
    end
  endtask
  task t_cascade;
    begin
      wr(4'h1, 16'h0100); time_base_ticks <= 6'h0; run(2);
      chk("cascade_alone", 16'h0, {15'h0, cascade_active});
      partner_cascade_enable <= 1'b1; run(2);
      chk("cascade_pair", 16'h1, {15'h0, cascade_active});
      rd(4'h5); c0 = d;
      @(posedge clock); carry_in <= 1'b1;
      @(posedge clock); carry_in <= 1'b0;
      rd(4'h5); chk("carry_step", c0 + 16'h1, d);
      $display("test cascade done");
    end
  endtask

  // ----------------------------------------
  // verdict and sequence
  // ----------------------------------------
  task print_verdict;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  // the wrap test dominates the run time
  initial
  begin
    repeat (80000) @(posedge clock);
    mismatches = mismatches + 1;
    print_verdict;
  end

  initial
  begin
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    t_reset;
    t_wrap;
    t_single;
    t_cont;
    t_sync_trig;
    t_cascade;
    print_verdict;
  end
endmodule
